// ### synth_freq_pkg.sv
// shared constants for the synthesizer frequency register link
package synth_freq_pkg;
  localparam int WORD_BITS = 24;
  // register select codes in the three lowest word bits
  localparam logic [2:0] SELECT_FREQ  = 3'h0;
  localparam logic [2:0] SELECT_MOD   = 3'h1;
  localparam logic [2:0] SELECT_PHASE = 3'h2;
  // field positions of the frequency word register
  localparam int INT_HI  = 23;
  localparam int INT_LO  = 15;
  localparam int FRACTION_NUMERATOR_HI = 14;
  localparam int FRACTION_NUMERATOR_LO = 3;
  // field positions of the modulus/reference register
  localparam int BOOST_BIT    = 23;
  localparam int HALVER_BIT   = 22;
  localparam int RESERVED_BIT = 21;
  localparam int EIGHT_BIT    = 20;
  localparam int DOUBLER_BIT  = 19;
  localparam int RDIV_HI      = 18;
  localparam int RDIV_LO      = 15;
  localparam int MOD_HI       = 14;
  localparam int MOD_LO       = 3;
  // phase register field
  localparam int PHASE_HI = 14;
  localparam int PHASE_LO = 3;
  // legal ranges
  localparam logic [8:0]  INT_MIN_FOUR  = 9'h01a;
  localparam logic [8:0]  INT_MIN_EIGHT = 9'h050;
  localparam logic [11:0] MOD_MIN       = 12'h00d;
  // values after reset
  localparam logic [8:0]  RESET_INT     = 9'h01a;
  localparam logic [11:0] RESET_MOD     = 12'hfff;
  localparam logic [3:0]  RESET_RDIV    = 4'h1;
  // fast lock timers advance once per four phase-detector cycles; last value of the quarter count
  localparam logic [1:0]  QUARTER_LAST  = 2'h3;
  // serial clock half period
  localparam int CLK_PERIOD_NS      = 4;
  localparam int SERIAL_HALF_NS     = 20;
  localparam int SERIAL_HALF_CYCLES = (SERIAL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host register offsets
  localparam logic [7:0] REG_TX_WORD = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_COUNT   = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0c;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : synth_freq_pkg

// ### synth_serial_if.sv
// three-wire serial link between host controller and synthesizer
`timescale 1ns/1ps
interface synth_serial_if;
  logic serialClock;
  logic serialData;
  logic loadStrobe;
  modport host   (output serialClock, output serialData, output loadStrobe);
  modport device (input serialClock, input serialData, input loadStrobe);
endinterface : synth_serial_if

// ### quarter_timeout.sv
// fast lock timeout counter, active from start until count ticks pass
`timescale 1ns/1ps
module quarter_timeout #(
  parameter int COUNT_BITS = 9
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic                  tick,
  input  wire logic [COUNT_BITS-1:0] count,
  output logic                       active
);
  typedef struct packed {
    logic [COUNT_BITS-1:0] remaining;
    logic                  active;
  } state_s;
  state_s q;
  state_s next_q;

  // restart wins over a running count
  always_comb begin
    next_q = q;
    if (start) begin
      next_q.remaining = count;
      next_q.active    = (count != '0);
    end else if (tick && q.active) begin
      next_q.remaining = q.remaining - 1'b1;
      next_q.active    = (q.remaining != {{(COUNT_BITS-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign active = q.active;
endmodule : quarter_timeout

// ### synth_freq_device.sv
// synthesizer end: serial capture, double buffering and fast lock start
// Summary of operation
// - 24-bit word, msb first, latched on strobe
// - select 000 picks frequency word register
// - next reference cycle loads divider, starts fast lock
// - fast lock holds pump max, switches closed
// - timeouts advance every four reference cycles
// - channel change needs only frequency word write
// - modulus and phase applied at frequency write
// - integer in bits 23..15, 26 to 511
// - fraction in bits 14..3, below modulus
// - select 001 picks modulus/reference register
// - modulus, divider, doubler, halver, boost held back
// - boost bit raises pump current 25 percent
// - halver divides divider output by two
// - host writes zero into bit 21
// - host picks 8/9 above 3 GHz
// - integer minimum 26 at 4/5, 80 at 8/9
// - doubler enable inserts reference doubler
// - reference divider 4 bits, 1 to 15
// - host keeps modulus within 13 to 4095
// - channel step is reference over modulus
`timescale 1ns/1ps
module synth_freq_device #(
  parameter int TIMEOUT_BITS = 9
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  synth_serial_if.device               serialLink,
  input  wire logic                    referenceInput,
  input  wire logic [TIMEOUT_BITS-1:0] pumpTimeout,
  input  wire logic [TIMEOUT_BITS-1:0] switchAbTimeout,
  input  wire logic [TIMEOUT_BITS-1:0] switchCTimeout,
  output logic [8:0]                   integerValue,
  output logic [11:0]                  fractionNumerator,
  output logic [11:0]                  fractionModulus,
  output logic [3:0]                   referenceDivider,
  output logic                         doublerEnable,
  output logic                         referenceHalver,
  output logic                         prescalerEight,
  output logic                         pumpBoostAdjust,
  output logic [11:0]                  phaseWord,
  output logic                         pfdTick,
  output logic                         fastLock,
  output logic                         pumpCurrentMax,
  output logic                         loopFilterSwitchA,
  output logic                         loopFilterSwitchB,
  output logic                         loopFilterSwitchC
);
  typedef struct packed {
    logic        serialClockPrev;
    logic        loadStrobePrev;
    logic        referencePrev;
    logic [23:0] shiftWord;
    logic [20:0] freqBuffer;
    logic [20:0] modBuffer;
    logic [11:0] phaseBuffer;
    logic        freqPending;
    logic [3:0]  refCount;
    logic        halfToggle;
    logic        pfdTick;
    logic [1:0]  quarterCount;
    logic        quarterTick;
    logic        fastLock;
    logic [8:0]  integerValue;
    logic [11:0] fractionNumerator;
    logic [11:0] fractionModulus;
    logic [3:0]  referenceDivider;
    logic        doublerEnable;
    logic        referenceHalver;
    logic        prescalerEight;
    logic        pumpBoostAdjust;
    logic [11:0] phaseWord;
  } state_s;

  state_s q;
  state_s next_q;

  // edge detects on pins sampled synchronously to clk
  wire logic       clockRise  = serialLink.serialClock & ~q.serialClockPrev;
  wire logic       strobeRise = serialLink.loadStrobe & ~q.loadStrobePrev;
  wire logic [2:0] selectBits = q.shiftWord[2:0];
  wire logic       refRise    = referenceInput & ~q.referencePrev;
  wire logic       refFall    = ~referenceInput & q.referencePrev;
  // doubling is done by counting both reference edges
  wire logic       refEdge    = q.doublerEnable ? (refRise | refFall) : refRise;
  // a programmed divider of zero behaves as one
  wire logic       divDone    = refEdge &&
                                ({1'b0, q.refCount} + 5'h01 >= {1'b0, q.referenceDivider});
  // commit only on a reference cycle with a frequency write waiting
  wire logic       commit     = q.pfdTick && q.freqPending;
  wire logic       pumpActive;
  wire logic       switchAbActive;
  wire logic       switchCActive;

  always_comb begin
    next_q                 = q;
    next_q.serialClockPrev = serialLink.serialClock;
    next_q.loadStrobePrev  = serialLink.loadStrobe;
    next_q.referencePrev   = referenceInput;

    // shift on rising serial clock, msb first
    if (clockRise) begin
      next_q.shiftWord = {q.shiftWord[22:0], serialLink.serialData};
    end

    // pending clears on commit; a write in the same cycle keeps it set
    if (commit) begin
      next_q.freqPending = 1'b0;
    end

    // load strobe routes the word by its select bits
    if (strobeRise) begin
      if (selectBits == synth_freq_pkg::SELECT_FREQ) begin
        next_q.freqBuffer  = q.shiftWord[23:3];
        next_q.freqPending = 1'b1;
      end else if (selectBits == synth_freq_pkg::SELECT_MOD) begin
        next_q.modBuffer   = q.shiftWord[23:3];
      end else if (selectBits == synth_freq_pkg::SELECT_PHASE) begin
        next_q.phaseBuffer = q.shiftWord[synth_freq_pkg::PHASE_HI:synth_freq_pkg::PHASE_LO];
      end
    end

    // reference divider and optional halver produce the detector tick
    if (refEdge) begin
      next_q.refCount = divDone ? 4'h0 : q.refCount + 4'h1;
    end
    if (divDone) begin
      next_q.halfToggle = ~q.halfToggle;
    end
    next_q.pfdTick = divDone && (!q.referenceHalver || q.halfToggle);

    // quarter-rate tick for the timeout counters, realigned at commit
    if (commit) begin
      next_q.quarterCount = 2'h0;
    end else if (q.pfdTick) begin
      next_q.quarterCount = q.quarterCount + 2'h1;
    end
    next_q.quarterTick = q.pfdTick && !commit &&
                         (q.quarterCount == synth_freq_pkg::QUARTER_LAST);

    // all buffered fields move in one cycle, never piecemeal
    if (commit) begin
      next_q.integerValue      = q.freqBuffer[synth_freq_pkg::INT_HI-3:synth_freq_pkg::INT_LO-3];
      next_q.fractionNumerator = q.freqBuffer[synth_freq_pkg::FRACTION_NUMERATOR_HI-3:synth_freq_pkg::FRACTION_NUMERATOR_LO-3];
      // step size follows the new modulus from here on
      next_q.fractionModulus   = q.modBuffer[synth_freq_pkg::MOD_HI-3:synth_freq_pkg::MOD_LO-3];
      next_q.referenceDivider  = q.modBuffer[synth_freq_pkg::RDIV_HI-3:synth_freq_pkg::RDIV_LO-3];
      next_q.doublerEnable     = q.modBuffer[synth_freq_pkg::DOUBLER_BIT-3];
      next_q.referenceHalver   = q.modBuffer[synth_freq_pkg::HALVER_BIT-3];
      next_q.prescalerEight    = q.modBuffer[synth_freq_pkg::EIGHT_BIT-3];
      next_q.pumpBoostAdjust   = q.modBuffer[synth_freq_pkg::BOOST_BIT-3];
      next_q.phaseWord         = q.phaseBuffer;
    end

    // any running timer keeps the loop in fast lock
    next_q.fastLock = pumpActive | switchAbActive | switchCActive;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q                   <= '0;
      q.freqBuffer        <= {synth_freq_pkg::RESET_INT, 12'h000};
      q.modBuffer         <= {5'h00, synth_freq_pkg::RESET_RDIV, synth_freq_pkg::RESET_MOD};
      q.integerValue      <= synth_freq_pkg::RESET_INT;
      q.fractionModulus   <= synth_freq_pkg::RESET_MOD;
      q.referenceDivider  <= synth_freq_pkg::RESET_RDIV;
    end else begin
      q <= next_q;
    end
  end

  // pump current held at maximum until its own timer ends
  quarter_timeout #(.COUNT_BITS(TIMEOUT_BITS)) pumpTimer (
    .clk    (clk),
    .reset  (reset),
    .start  (commit),
    .tick   (q.quarterTick),
    .count  (pumpTimeout),
    .active (pumpActive)
  );

  // switches a and b share one timer
  quarter_timeout #(.COUNT_BITS(TIMEOUT_BITS)) switchAbTimer (
    .clk    (clk),
    .reset  (reset),
    .start  (commit),
    .tick   (q.quarterTick),
    .count  (switchAbTimeout),
    .active (switchAbActive)
  );

  quarter_timeout #(.COUNT_BITS(TIMEOUT_BITS)) switchCTimer (
    .clk    (clk),
    .reset  (reset),
    .start  (commit),
    .tick   (q.quarterTick),
    .count  (switchCTimeout),
    .active (switchCActive)
  );

  assign integerValue      = q.integerValue;
  assign fractionNumerator = q.fractionNumerator;
  assign fractionModulus   = q.fractionModulus;
  assign referenceDivider  = q.referenceDivider;
  assign doublerEnable     = q.doublerEnable;
  assign referenceHalver   = q.referenceHalver;
  assign prescalerEight    = q.prescalerEight;
  assign pumpBoostAdjust   = q.pumpBoostAdjust;
  assign phaseWord         = q.phaseWord;
  assign pfdTick           = q.pfdTick;
  assign fastLock          = q.fastLock;
  assign pumpCurrentMax    = pumpActive;
  assign loopFilterSwitchA = switchAbActive;
  assign loopFilterSwitchB = switchAbActive;
  assign loopFilterSwitchC = switchCActive;
endmodule : synth_freq_device

// ### synth_freq_host.sv
// host end: axi4-lite registers driving the three-wire serial link
`timescale 1ns/1ps
module synth_freq_host (
  input  wire logic        clk,
  input  wire logic        reset,
  synth_serial_if.host     serialLink,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {IDLE, SHIFT, STROBE} phase_e;
  typedef struct packed {
    logic        awready, wready, arready;
    logic        awTaken, wTaken;
    logic [7:0]  writeAddr;
    logic [31:0] writeData;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    phase_e      phase;
    logic [7:0]  divCount;
    logic [23:0] txWord;
    logic [23:0] shiftWord;
    logic [4:0]  bitCount;
    logic        serialClock, serialData, loadStrobe;
    logic        highBand;
    logic [11:0] lastModulus;
    logic        lastEight;
    logic [15:0] sentCount;
  } state_s;
  state_s q;
  state_s next_q;

  // one-cycle enable per serial half period
  wire logic tick = (q.divCount == 8'(synth_freq_pkg::SERIAL_HALF_CYCLES - 1));
  wire logic [23:0] newWord = q.writeData[23:0];

  // refuse words that break the programming limits
  function automatic logic wordLegal(input logic [23:0] w, input logic [11:0] lastMod,
                                     input logic lastEight, input logic highBand);
    logic ok;
    ok = 1'b1;
    if (w[2:0] == synth_freq_pkg::SELECT_FREQ) begin
      ok = (w[23:15] >= (lastEight ? synth_freq_pkg::INT_MIN_EIGHT
                                   : synth_freq_pkg::INT_MIN_FOUR))
        && (w[14:3] < lastMod);
    end else if (w[2:0] == synth_freq_pkg::SELECT_MOD) begin
      ok = !w[synth_freq_pkg::RESERVED_BIT]
        && (w[14:3] >= synth_freq_pkg::MOD_MIN)
        && (w[18:15] != 4'h0)
        && !(highBand && !w[synth_freq_pkg::EIGHT_BIT]);
    end
    return ok;
  endfunction : wordLegal

  always_comb begin
    next_q = q;
    // write address and data are taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.awTaken   = 1'b1;
      next_q.writeAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wTaken    = 1'b1;
      next_q.writeData = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    // perform the write once both halves are in
    if (q.awTaken && q.wTaken) begin
      next_q.awTaken = 1'b0;
      next_q.wTaken  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = synth_freq_pkg::RESP_OKAY;
      if (q.writeAddr == synth_freq_pkg::REG_TX_WORD) begin
        // a frame in flight cannot be interrupted, so a new word is refused
        if (q.phase != IDLE || !wordLegal(newWord, q.lastModulus, q.lastEight, q.highBand)) begin
          next_q.bresp = synth_freq_pkg::RESP_SLVERR;
        end else begin
          next_q.txWord      = newWord;
          next_q.shiftWord   = newWord;
          next_q.phase       = SHIFT;
          next_q.bitCount    = 5'h00;
          next_q.divCount    = 8'h00;
          next_q.serialData  = newWord[23];
          if (newWord[2:0] == synth_freq_pkg::SELECT_MOD) begin
            next_q.lastModulus = newWord[14:3];
            next_q.lastEight   = newWord[synth_freq_pkg::EIGHT_BIT];
          end
        end
      end else if (q.writeAddr == synth_freq_pkg::REG_CONTROL) begin
        if (s_axi_wstrb[0]) begin
          next_q.highBand = q.writeData[0];
        end
      end else begin
        next_q.bresp = synth_freq_pkg::RESP_SLVERR;
      end
    end

    // read decode
    if (s_axi_rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = synth_freq_pkg::RESP_OKAY;
      if (s_axi_araddr == synth_freq_pkg::REG_TX_WORD) begin
        next_q.rdata = {8'h00, q.txWord};
      end else if (s_axi_araddr == synth_freq_pkg::REG_STATUS) begin
        next_q.rdata = {30'h0, q.highBand, q.phase != IDLE};
      end else if (s_axi_araddr == synth_freq_pkg::REG_COUNT) begin
        next_q.rdata = {16'h0000, q.sentCount};
      end else if (s_axi_araddr == synth_freq_pkg::REG_CONTROL) begin
        next_q.rdata = {31'h0, q.highBand};
      end else begin
        next_q.rdata = 32'h0;
        next_q.rresp = synth_freq_pkg::RESP_SLVERR;
      end
    end

    // serial engine: data changes while clock is low, msb first
    if (q.phase != IDLE) begin
      next_q.divCount = tick ? 8'h00 : q.divCount + 8'h01;
    end
    if (tick) begin
      if (q.phase == SHIFT) begin
        if (!q.serialClock) begin
          next_q.serialClock = 1'b1;
        end else begin
          next_q.serialClock = 1'b0;
          if (q.bitCount == 5'(synth_freq_pkg::WORD_BITS - 1)) begin
            next_q.phase      = STROBE;
            next_q.loadStrobe = 1'b1;
          end else begin
            next_q.bitCount   = q.bitCount + 5'h01;
            next_q.shiftWord  = {q.shiftWord[22:0], 1'b0};
            next_q.serialData = q.shiftWord[22];
          end
        end
      end else if (q.phase == STROBE) begin
        next_q.loadStrobe = 1'b0;
        next_q.phase      = IDLE;
        next_q.sentCount  = q.sentCount + 16'h0001;
      end
    end

    // readies are registered; one write and one read at a time
    next_q.awready = ~next_q.awTaken & ~next_q.bvalid & ~(q.awTaken & q.wTaken);
    next_q.wready  = ~next_q.wTaken & ~next_q.bvalid & ~(q.awTaken & q.wTaken);
    next_q.arready = ~next_q.rvalid;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q             <= '0;
      q.phase       <= IDLE;
      q.lastModulus <= synth_freq_pkg::RESET_MOD;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready          = q.awready;
  assign s_axi_wready           = q.wready;
  assign s_axi_bvalid           = q.bvalid;
  assign s_axi_bresp            = q.bresp;
  assign s_axi_arready          = q.arready;
  assign s_axi_rvalid           = q.rvalid;
  assign s_axi_rdata            = q.rdata;
  assign s_axi_rresp            = q.rresp;
  assign serialLink.serialClock = q.serialClock;
  assign serialLink.serialData  = q.serialData;
  assign serialLink.loadStrobe  = q.loadStrobe;
endmodule : synth_freq_host

// ### synth_serial_chk.sv
// wire-level checker for the three-wire synthesizer link
`timescale 1ns/1ps
module synth_serial_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic loadStrobe
);
  logic [23:0] word;
  logic [4:0]  rises;
  logic        lastClock;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // rebuild each frame as the far end captures it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word      <= 24'h000000;
      rises     <= 5'h00;
      lastClock <= 1'b0;
    end else begin
      lastClock <= serialClock;
      if (loadStrobe) begin
        rises <= 5'h00;
      end else if (serialClock && !lastClock) begin
        word  <= {word[22:0], serialData};
        rises <= rises + 5'h01;
      end
    end
  end
  sequence s_strobePulse;
    loadStrobe [*5] ##1 !loadStrobe;
  endsequence
  sequence s_frameEnd;
    $rose(loadStrobe);
  endsequence
  property p_halfPeriod;
    $changed(serialClock) |=> $stable(serialClock) [*4];
  endproperty
  property p_strobeWidth;
    s_frameEnd |-> s_strobePulse;
  endproperty
  property p_clockLowInStrobe;
    loadStrobe |-> !serialClock;
  endproperty
  property p_dataSteady;
    serialClock |-> $stable(serialData);
  endproperty
  property p_frameLength;
    s_frameEnd |-> rises == 5'h18;
  endproperty
  property p_strobeGap;
    s_frameEnd |-> $past(serialClock, 5) == 1'b1;
  endproperty
  property p_intFloor;
    $rose(loadStrobe) && word[2:0] == synth_freq_pkg::SELECT_FREQ |-> word[23:15] >= 9'h01a;
  endproperty
  property p_modFields;
    $rose(loadStrobe) && word[2:0] == synth_freq_pkg::SELECT_MOD
      |-> !word[21] && word[14:3] >= 12'h00d && word[18:15] != 4'h0;
  endproperty
  a_halfPeriod: assert property (p_halfPeriod) else $error("clock half short");
  a_strobeWidth: assert property (p_strobeWidth) else $error("strobe width");
  a_clockLowInStrobe: assert property (p_clockLowInStrobe) else $error("clock in strobe");
  a_dataSteady: assert property (p_dataSteady) else $error("data moved high");
  a_frameLength: assert property (p_frameLength) else $error("frame length");
  a_strobeGap: assert property (p_strobeGap) else $error("strobe too early");
  a_intFloor: assert property (p_intFloor) else $error("integer too low");
  a_modFields: assert property (p_modFields) else $error("bad modulus word");
endmodule : synth_serial_chk

// ### synth_frequency_registers_bench.sv
// host and synthesizer ends joined by the serial link, driven over axi4-lite
`timescale 1ns/1ps
module synth_frequency_registers_bench;
  logic clk = 1'b0, reset = 1'b1, referenceInput = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, respQ[$], rrQ[$];
  logic [31:0] rdQ[$], rmQ[$];
  logic [40:0] setQ[$], settings;
  logic [23:0] mw, fw;
  logic [8:0] integerValue, n;
  logic [11:0] fractionNumerator, fractionModulus, phaseWord, f;
  logic [3:0] referenceDivider;
  logic doublerEnable, referenceHalver, prescalerEight, pumpBoostAdjust, pfdTick, fastLock;
  logic pumpCurrentMax, loopFilterSwitchA, loopFilterSwitchB, loopFilterSwitchC, pumpPrev = 1'b0;
  int failures = 0, checkCount = 0, ticks = 0, seed = 96623;
  localparam logic [1:0] OK = synth_freq_pkg::RESP_OKAY, ERR = synth_freq_pkg::RESP_SLVERR;
  synth_serial_if link ();
  synth_freq_host i_synth_freq_host (.clk, .reset, .serialLink(link), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  synth_freq_device i_synth_freq_device (.clk, .reset, .serialLink(link), .referenceInput,
    .pumpTimeout(9'h003), .switchAbTimeout(9'h002), .switchCTimeout(9'h001), .integerValue,
    .fractionNumerator, .fractionModulus, .referenceDivider, .doublerEnable, .referenceHalver,
    .prescalerEight, .pumpBoostAdjust, .phaseWord, .pfdTick, .fastLock, .pumpCurrentMax,
    .loopFilterSwitchA, .loopFilterSwitchB, .loopFilterSwitchC);
  synth_serial_chk i_synth_serial_chk (.clk(clk), .reset(reset), .serialClock(link.serialClock),
    .serialData(link.serialData), .loadStrobe(link.loadStrobe));
  assign settings = {integerValue, fractionNumerator, fractionModulus, referenceDivider,
    doublerEnable, referenceHalver, prescalerEight, pumpBoostAdjust};
  always #2 clk = ~clk;
  // each reference level lasts 3 clk
  always begin
    repeat (3) @(posedge clk);
    referenceInput <= ~referenceInput;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // what the synthesizer should show once a frequency word is committed
  function automatic logic [40:0] expSet(input logic [23:0] fq, input logic [23:0] md);
    return {fq[23:3], md[14:3], md[18:15], md[19], md[22], md[20], md[23]};
  endfunction : expSet
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] r);
    respQ.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : axiWrite
  task automatic tx(input logic [23:0] w, input logic [1:0] r);
    axiWrite(synth_freq_pkg::REG_TX_WORD, {8'h00, w}, r);
  endtask : tx
  task automatic axiRead(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    rdQ.push_back(e);
    rmQ.push_back(m);
    rrQ.push_back(r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axiRead
  // polling reads carry a zero mask: only their response code is judged
  task automatic waitIdle;
    d = 32'h1;
    while (d[0]) axiRead(synth_freq_pkg::REG_STATUS, 32'h0, 32'h0, OK);
  endtask : waitIdle
  task automatic sendFreq(input logic [8:0] ni, input logic [11:0] fi);
    fw = {ni, fi, 3'h0};
    setQ.push_back(expSet(fw, mw));
    tx(fw, OK);
  endtask : sendFreq
  // watcher: each result takes the oldest note of its kind
  always @(posedge clk) begin
    pumpPrev <= pumpCurrentMax;
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, respQ.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      check(s_axi_rresp, rrQ.pop_front());
      check(s_axi_rdata & rmQ.pop_front(), rdQ.pop_front());
    end
    if (pumpCurrentMax && !pumpPrev) begin
      check(settings, setQ.pop_front());
      check({loopFilterSwitchA, loopFilterSwitchB, loopFilterSwitchC}, 3'h7);
    end
    if (pumpCurrentMax && pfdTick) ticks++;
    if (!pumpCurrentMax && pumpPrev) begin
      check(ticks, 12);
      ticks = 0;
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check(settings, {9'h01a, 12'h000, 12'hfff, 4'h1, 4'h0});
    axiRead(8'h10, 32'h0, 32'hffffffff, ERR);
    axiWrite(8'h10, 32'h0, ERR);
    mw = {4'h9, 1'b1, 4'h2, 12'h064, 3'h1};
    tx(mw, OK);
    waitIdle();
    check(fractionModulus, 12'hfff);
    for (int i = 0; i < 3; i++) begin
      n = 9'h050 + 9'($unsigned($random(seed)) % 432);
      f = 12'($unsigned($random(seed)) % 100);
      sendFreq(n, f);
      if (i == 0) tx(fw, ERR);
      waitIdle();
      @(posedge clk iff fastLock);
      @(posedge clk iff !fastLock);
    end
    tx(24'h0c8000, ERR);
    tx(24'h280320, ERR);
    tx(mw | 24'h200000, ERR);
    tx(mw & 24'hf87fff, ERR);
    tx(24'h010061, ERR);
    axiWrite(synth_freq_pkg::REG_CONTROL, 32'h1, OK);
    tx(mw & 24'hefffff, ERR);
    mw = {4'h5, 1'b0, 4'hf, 12'h00d, 3'h1};
    tx(mw, OK);
    waitIdle();
    tx(24'h278000, ERR);
    tx({9'h000, 12'h5a5, 3'h2}, OK);
    waitIdle();
    check(phaseWord, 12'h000);
    sendFreq(9'h050, 12'h00c);
    waitIdle();
    @(posedge clk iff fastLock);
    @(posedge clk iff !fastLock);
    axiRead(synth_freq_pkg::REG_TX_WORD, {8'h00, fw}, 32'h00ffffff, OK);
    axiRead(synth_freq_pkg::REG_COUNT, 32'h7, 32'hffffffff, OK);
    axiRead(synth_freq_pkg::REG_STATUS, 32'h2, 32'h3, OK);
    check(phaseWord, 12'h5a5);
    print_verdict();
  end
endmodule : synth_frequency_registers_bench
